/* core/fcd_bus_cycle.sv */
// one flash bus cycle: a write strobe pulse or a timed read
`timescale 1ns/10ps
module fcd_bus_cycle
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // request side
  input  wire logic              start_wr,
  input  wire logic              start_rd,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   cyc_done,
  output logic [DATA_W-1:0]      rd_data,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n
);
  fcd_bus_t          state, next_state;
  logic [7:0]        cnt, next_cnt;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dq, next_rd;

  // ****************************************************
  // cycle sequencer: device latches on the rising we edge
  // ****************************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_addr  = flash_addr;
    next_dq    = flash_dq_out;
    next_rd    = rd_data;
    cyc_done   = 1'b0;
    case (state)
      FCD_IDLE: begin
        if (start_wr) begin
          next_addr  = req_addr;
          next_dq    = req_data;
          next_cnt   = WE_LOW_CYC;
          next_state = FCD_WR_LOW;
        end else if (start_rd) begin
          next_addr  = req_addr;
          next_cnt   = READ_CYC;
          next_state = FCD_RD_LOW;
        end
      end
      FCD_WR_LOW: begin
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE) begin
          next_cnt   = GAP_CYC;
          next_state = FCD_WR_GAP;
        end
      end
      FCD_WR_GAP: begin
        // data held one cycle past the strobe for hold time
        cyc_done   = 1'b1;
        next_state = FCD_IDLE;
      end
      FCD_RD_LOW: begin
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE) begin
          next_rd    = flash_dq_in;
          next_state = FCD_WAIT;
        end
      end
      FCD_WAIT: begin
        cyc_done   = 1'b1;
        next_state = FCD_IDLE;
      end
      default: next_state = FCD_IDLE;
    endcase
  end

  // registered pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= FCD_IDLE;
      cnt          <= CNT_ZERO;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      rd_data      <= '0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      flash_addr   <= next_addr;
      flash_dq_out <= next_dq;
      rd_data      <= next_rd;
    end
  end

  // strobes follow state; drive dq only across the write
  assign flash_we_n  = (state != FCD_WR_LOW);
  assign flash_dq_oe = (state == FCD_WR_LOW) || (state == FCD_WR_GAP);
  assign flash_oe_n  = (state != FCD_RD_LOW);
  assign flash_ce_n  = (state == FCD_IDLE) || (state == FCD_WAIT);

  // write strobe width is exact
  we_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n)
    else $error("write strobe width wrong");
  // no bus fight during reads
  no_fight_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flash_oe_n |-> !flash_dq_oe)
    else $error("dq driven while output enabled");
endmodule

/* core/fcd_host.sv */
// flash command host: turns user operations into unlock and command write sequences
`timescale 1ns/10ps
// What this block does
// - unlock pair precedes every multi-cycle command
// - program is unlock, A0h, address and data
// - extra blocks added by a lone 30h write; timer flag not checked
// - chip erase sixth write is 10h
// - pause byte alone, then poll toggle
// - wait recovery after reset of paused flash
module fcd_host
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // user command port
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire logic [3:0]        op_code,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [DATA_W-1:0] op_data,
  output logic                   op_done,
  output logic [DATA_W-1:0]      op_rdata,
  output logic                   erase_busy,
  output logic                   erase_paused,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  input  wire logic              ready_busy_out
);
  typedef enum logic [2:0] {HS_IDLE, HS_WRITE, HS_READ, HS_POLL, HS_RECOVER} fcd_host_t;

  fcd_host_t         state, next_state;
  logic [2:0]        step, next_step, last_step, next_last;
  logic [3:0]        op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] data, next_data;
  logic [DATA_W-1:0] prev_stat, next_prev;
  logic              busy, next_busy, paused, next_paused, polled, next_polled;
  logic [7:0]        wait_cnt, next_wait;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic              done, next_done;
  logic              start_wr, start_rd, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_data, rd_data;

  // step addressing of the unlock pair; upper lines left low
  function automatic logic [ADDR_W-1:0] unlock_addr(input logic [2:0] s);
    unlock_addr = s[0] ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
  endfunction
  function automatic logic [DATA_W-1:0] unlock_byte(input logic [2:0] s);
    unlock_byte = s[0] ? UNLOCK_BYTE2 : UNLOCK_BYTE1;
  endfunction

  // ****************************************************
  // write sequence for the current step of an operation
  // ****************************************************
  always_comb begin
    cyc_addr = addr;
    cyc_data = data;
    case (op)
      OP_RESET, OP_IDENT, OP_PROGRAM: begin
        if (step < 3'h2) begin
          cyc_addr = unlock_addr(step);
          cyc_data = unlock_byte(step);
        end else if (step == 3'h2) begin
          cyc_addr = UNLOCK_ADDR1;
          cyc_data = (op == OP_RESET) ? CMD_RESET :
                     (op == OP_IDENT) ? CMD_IDENT : CMD_PROGRAM;
        end
      end
      OP_BLK_ERASE, OP_CHIP_ERASE: begin
        if (step == 3'h2) begin
          cyc_addr = UNLOCK_ADDR1;
          cyc_data = CMD_SETUP;
        end else if (step < 3'h5) begin
          cyc_addr = unlock_addr(step == 3'h0 || step == 3'h3 ? 3'h0 : 3'h1);
          cyc_data = unlock_byte(step == 3'h0 || step == 3'h3 ? 3'h0 : 3'h1);
        end else if (op == OP_CHIP_ERASE) begin
          cyc_addr = UNLOCK_ADDR1;
          cyc_data = CMD_CHIP_CONF;
        end else begin
          cyc_data = CMD_BLK_CONF;
        end
      end
      OP_ADD_BLK:     cyc_data = CMD_BLK_CONF;
      OP_PAUSE:       cyc_data = CMD_PAUSE;
      OP_CONTINUE:    cyc_data = CMD_CONTINUE;
      OP_SHORT_RESET: cyc_data = CMD_RESET;
      default: begin
        cyc_addr = addr;
        cyc_data = data;
      end
    endcase
  end

  // ****************************************************
  // operation sequencer
  // ****************************************************
  always_comb begin
    next_state  = state;
    next_step   = step;
    next_last   = last_step;
    next_op     = op;
    next_addr   = addr;
    next_data   = data;
    next_prev   = prev_stat;
    next_busy   = busy;
    next_paused = paused;
    next_polled = polled;
    next_wait   = wait_cnt;
    next_rdata  = rdata;
    next_done   = 1'b0;
    start_wr    = 1'b0;
    start_rd    = 1'b0;
    case (state)
      HS_IDLE: begin
        if (op_valid) begin
          next_op     = op_code;
          next_addr   = op_addr;
          next_data   = op_data;
          next_step   = STEP_ZERO;
          next_polled = 1'b0;
          case (op_code)
            OP_RESET, OP_IDENT: next_last = 3'h2;
            OP_PROGRAM:         next_last = 3'h3;
            OP_BLK_ERASE, OP_CHIP_ERASE: next_last = 3'h5;
            default:            next_last = STEP_ZERO;
          endcase
          // reads of identification or array go straight out
          next_state = (op_code == OP_READ) ? HS_READ : HS_WRITE;
        end
      end
      HS_WRITE: begin
        start_wr = (step != 3'h7);
        if (cyc_done) begin
          if (step == last_step) begin
            case (op)
              OP_PROGRAM, OP_BLK_ERASE, OP_CHIP_ERASE, OP_CONTINUE: begin
                next_busy  = (op != OP_PROGRAM) || busy;
                next_paused = (op == OP_PROGRAM) && paused;
                next_state = HS_POLL;
              end
              OP_PAUSE: begin
                next_paused = 1'b1;
                next_state  = HS_POLL;
              end
              OP_RESET, OP_SHORT_RESET: begin
                next_wait   = RECOVER_CYC;
                next_busy   = 1'b0;
                next_paused = 1'b0;
                next_state  = (busy || paused) ? HS_RECOVER : HS_IDLE;
                next_done   = !(busy || paused);
              end
              default: begin
                next_state = HS_IDLE;
                next_done  = 1'b1;
              end
            endcase
            next_step = 3'h7;
          end else begin
            next_step = step + STEP_ONE;
          end
        end
      end
      HS_READ: begin
        start_rd = !cyc_done;
        if (cyc_done) begin
          next_rdata = rd_data;
          next_done  = 1'b1;
          next_state = HS_IDLE;
        end
      end
      HS_POLL: begin
        // wait for the toggle bit to settle across two reads
        start_rd = !cyc_done;
        if (cyc_done) begin
          next_prev   = rd_data;
          next_polled = 1'b1;
          if (polled && (rd_data[TOGGLE_BIT] == prev_stat[TOGGLE_BIT])) begin
            next_rdata = rd_data;
            next_busy  = busy && paused;
            next_done  = 1'b1;
            next_state = HS_IDLE;
          end
        end
      end
      HS_RECOVER: begin
        next_wait = wait_cnt - CNT_ONE;
        if (wait_cnt == CNT_ONE) begin
          next_done  = 1'b1;
          next_state = HS_IDLE;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= HS_IDLE;
      step      <= STEP_ZERO;
      last_step <= STEP_ZERO;
      op        <= OP_READ;
      addr      <= '0;
      data      <= '0;
      prev_stat <= '0;
      busy      <= 1'b0;
      paused    <= 1'b0;
      polled    <= 1'b0;
      wait_cnt  <= CNT_ZERO;
      rdata     <= '0;
      done      <= 1'b0;
    end else begin
      state     <= next_state;
      step      <= next_step;
      last_step <= next_last;
      op        <= next_op;
      addr      <= next_addr;
      data      <= next_data;
      prev_stat <= next_prev;
      busy      <= next_busy;
      paused    <= next_paused;
      polled    <= next_polled;
      wait_cnt  <= next_wait;
      rdata     <= next_rdata;
      done      <= next_done;
    end
  end

  assign op_ready     = (state == HS_IDLE);
  assign op_done      = done;
  assign op_rdata     = rdata;
  assign erase_busy   = busy;
  assign erase_paused = paused;

  // one bus cycle engine shared by writes and reads
  fcd_bus_cycle u_bus (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .start_wr     (start_wr),
    .start_rd     (start_rd),
    .req_addr     (cyc_addr),
    .req_data     (cyc_data),
    .cyc_done     (cyc_done),
    .rd_data      (rd_data),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );

  // unlock second byte always at its address
  unlock_two_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(flash_we_n) && flash_dq_out == UNLOCK_BYTE2 && op != OP_PROGRAM |->
      flash_addr == UNLOCK_ADDR2)
    else $error("second unlock byte at wrong address");
  // chip confirm goes to the fixed address; program data may carry the same byte
  chip_conf_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(flash_we_n) && flash_dq_out == CMD_CHIP_CONF && op != OP_PROGRAM |->
      flash_addr == UNLOCK_ADDR1)
    else $error("chip confirm at wrong address");
  // recovery wait holds ready low
  recover_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state == HS_RECOVER) |-> !op_ready [*8])
    else $error("recovery wait cut short");
  // pause is a single write
  pause_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(flash_we_n) && op == OP_PAUSE |-> flash_dq_out == CMD_PAUSE ##1 state == HS_POLL)
    else $error("pause byte wrong");
endmodule

/* core/fcd_pkg.sv */
// package: command codes, addresses, pin widths and timing for the flash command host
package fcd_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  // unlock addresses and bytes
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h02AAA;
  localparam logic [DATA_W-1:0] UNLOCK_BYTE1 = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK_BYTE2 = 8'h55;
  // command bytes
  localparam logic [DATA_W-1:0] CMD_RESET    = 8'hF0;
  localparam logic [DATA_W-1:0] CMD_IDENT    = 8'h90;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_SETUP    = 8'h80;
  localparam logic [DATA_W-1:0] CMD_BLK_CONF = 8'h30;
  localparam logic [DATA_W-1:0] CMD_CHIP_CONF = 8'h10;
  localparam logic [DATA_W-1:0] CMD_PAUSE    = 8'hB0;
  localparam logic [DATA_W-1:0] CMD_CONTINUE = 8'h30;
  // identification address offsets (A1:A0)
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 20'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 20'h00001;
  localparam logic [ADDR_W-1:0] ID_PROT_ADDR  = 20'h00002;
  // status bit positions
  localparam int TOGGLE_BIT = 6;
  localparam int TIMER_BIT  = 3;
  // user operation codes
  localparam logic [3:0] OP_RESET    = 4'h0;
  localparam logic [3:0] OP_IDENT    = 4'h1;
  localparam logic [3:0] OP_PROGRAM  = 4'h2;
  localparam logic [3:0] OP_BLK_ERASE = 4'h3;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h4;
  localparam logic [3:0] OP_PAUSE    = 4'h5;
  localparam logic [3:0] OP_CONTINUE = 4'h6;
  localparam logic [3:0] OP_ADD_BLK  = 4'h7;
  localparam logic [3:0] OP_READ     = 4'h8;
  localparam logic [3:0] OP_SHORT_RESET = 4'h9;
  // bus cycle timing at 50 ns per clock
  localparam int CLK_NS     = 50;
  localparam int WE_LOW_NS  = 100;
  localparam int READ_NS    = 150;
  localparam int RECOVER_NS = 500;
  localparam logic [7:0] WE_LOW_CYC  = 8'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] READ_CYC    = 8'((READ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RECOVER_CYC = 8'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GAP_CYC     = 8'h01;
  localparam logic [2:0] STEP_ZERO   = 3'h0;
  localparam logic [2:0] STEP_ONE    = 3'h1;
  localparam logic [7:0] CNT_ONE     = 8'h01;
  localparam logic [7:0] CNT_ZERO    = 8'h00;
  // bus engine states
  typedef enum logic [2:0] {FCD_IDLE, FCD_WR_LOW, FCD_WR_GAP, FCD_RD_LOW, FCD_WAIT}
    fcd_bus_t;
endpackage

/* testbench/fcd_flash_model.sv */
// flash device model: command decoder, byte array, ident and status reads
`timescale 1ns/10ps
module fcd_flash_model
  import fcd_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hC3, // arbitrary value
  parameter int         BUSY_RD  = 3
)(
  // flash pins
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_out,
  output logic      [DATA_W-1:0] flash_dq_in,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_we_n,
  input  wire logic              flash_oe_n,
  output logic                   ready_busy_out
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] mem [int];
  bit         eblk [int];
  int         step = 0;
  int         mode = 0;
  int         busy = 0;
  int         nxt;
  bit         paused = 0;
  bit         chip = 0;
  bit         u1;
  bit         u2;
  logic       tog = 1'b0;
  logic       timer = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] rd;
  logic [7:0] d;
  int         kq [$];

  // read data; released bus shows inverse of last value so stale bytes never match
  always @* begin
    if (busy > 0) rd = {1'b0, tog, 2'b00, timer, 3'b000};
    else if (mode == 1) begin
      case (flash_addr[1:0])
        2'b00:   rd = MAKER_ID;
        2'b01:   rd = PART_ID;
        2'b10:   rd = {7'h00, flash_addr[19:13] == 7'h7F};
        default: rd = 8'hFF;
      endcase
    end else rd = mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF;
    flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd : ~last;
    ready_busy_out = (busy == 0);
  end

  // end of each read while busy: toggle advances, erase finishes after a few polls
  always @(posedge flash_oe_n) begin
    last = rd;
    if (busy > 0) begin
      tog = ~tog;
      timer = 1'b1;
      busy--;
      if (busy == 0) begin
        kq.delete();
        foreach (mem[k]) if (chip || eblk.exists(k >> 13)) kq.push_back(k);
        foreach (kq[i]) mem.delete(kq[i]);
        eblk.delete();
        chip = 0;
      end
    end
  end

  // write cycles latched on the rising strobe
  always @(posedge flash_we_n) begin
    u1 = flash_addr[14:0] == UNLOCK_ADDR1[14:0];
    u2 = flash_addr[14:0] == UNLOCK_ADDR2[14:0];
    d = flash_dq_out;
    nxt = 0;
    if (flash_ce_n) nxt = step;
    else if (step == 3) begin
      if (!(paused && eblk.exists(flash_addr >> 13))) begin
        mem[flash_addr] = (mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF) & d;
        busy = BUSY_RD;
      end
    end else if (d == CMD_RESET) begin
      mode = 0;
      busy = 0;
      paused = 0;
      eblk.delete();
    end else if (step == 0 && u1 && d == UNLOCK_BYTE1) nxt = 1;
    else if (step == 0 && d == CMD_PAUSE) begin
      paused = 1;
      busy = 0;
    end else if (step == 0 && d == CMD_CONTINUE) begin
      if (!paused) eblk[flash_addr >> 13] = 1;
      paused = 0;
      busy = BUSY_RD;
    end else if (step == 1 && u2 && d == UNLOCK_BYTE2) nxt = 2;
    else if (step == 2 && d == CMD_IDENT) mode = 1;
    else if (step == 2 && u1 && d == CMD_PROGRAM) nxt = 3;
    else if (step == 2 && u1 && d == CMD_SETUP) nxt = 4;
    else if (step == 4 && u1 && d == UNLOCK_BYTE1) nxt = 5;
    else if (step == 5 && u2 && d == UNLOCK_BYTE2) nxt = 6;
    else if (step == 6 && d == CMD_BLK_CONF) begin
      eblk[flash_addr >> 13] = 1;
      busy = BUSY_RD;
      timer = 1'b0;
    end else if (step == 6 && u1 && d == CMD_CHIP_CONF) begin
      chip = 1;
      busy = BUSY_RD;
    end else mode = 0;
    if (nxt >= 3 || busy > 0) mode = 0;
    step = nxt;
  end
endmodule

/* testbench/test_flash_command_decoder.sv */
// testbench for the flash command host against the flash model
`timescale 1ns/10ps
module test_flash_command_decoder;
  import fcd_pkg::*;
  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              op_valid = 1'b0;
  logic [3:0]        op_code = 4'h0;
  logic [ADDR_W-1:0] op_addr = 20'h00000;
  logic [7:0]        op_data = 8'h00;
  logic              op_ready, op_done, erase_busy, erase_paused, dq_oe, ce_n, we_n, oe_n, rb;
  logic [7:0]        op_rdata, dq_o, dq_i;
  logic [19:0]       f_addr, a, a0;
  logic [7:0]        exp_mem [int];
  logic [31:0]       seed = 32'hB170C8CC;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                kq [$];
  int                n0;
  logic [7:0]        pv;

  always #25 ref_clk = ~ref_clk;

  // the host must drive dq through every write strobe
  always @(posedge we_n) if (rst_n) cmp1(dq_oe, 1'b1);

  fcd_host DUT (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_done(op_done),
    .op_rdata(op_rdata), .erase_busy(erase_busy), .erase_paused(erase_paused),
    .flash_addr(f_addr), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_out(rb));

  fcd_flash_model FLASH (.flash_addr(f_addr), .flash_dq_out(dq_o), .flash_dq_in(dq_i),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_out(rb));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [7:0] ev(input logic [19:0] k);
    return exp_mem.exists(k) ? exp_mem[k] : 8'hFF;
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one user operation: hold the request until taken, then wait for done
  task automatic op(input logic [3:0] c, input logic [19:0] ad, input logic [7:0] dt);
    int n;
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = c;
    op_addr = ad;
    op_data = dt;
    @(posedge ref_clk);
    while (op_ready !== 1'b1) @(posedge ref_clk);
    @(negedge ref_clk);
    op_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 3000) fail_count++;
  endtask

  task automatic rd_chk(input logic [19:0] ad);
    op(OP_READ, ad, 8'h00);
    cmp8(op_rdata, ev(ad));
  endtask

  // expected effect of an erase on the bench's copy of the array
  task automatic erase_exp(input logic [19:0] ad, input bit all);
    kq.delete();
    foreach (exp_mem[k]) if (all || (k >> 13) == (ad >> 13)) kq.push_back(k);
    foreach (kq[i]) exp_mem.delete(kq[i]);
  endtask

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      test_done;
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    op(OP_IDENT, 20'h00000, 8'h00);
    op(OP_READ, ID_MAKER_ADDR, 8'h00); cmp8(op_rdata, 8'h5A);
    op(OP_READ, ID_PART_ADDR, 8'h00); cmp8(op_rdata, 8'hC3);
    op(OP_READ, 20'hFE002, 8'h00); cmp8(op_rdata, 8'h01);
    op(OP_READ, 20'h02002, 8'h00); cmp8(op_rdata, 8'h00);
    op(OP_SHORT_RESET, 20'h00000, 8'h00);
    rd_chk(20'h00000);
    $display("ident test done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      a = {3'h0, seed[16:0]};
      if (i == 0) a0 = a;
      op(OP_PROGRAM, a, seed[31:24]);
      exp_mem[a] = ev(a) & seed[31:24];
      rd_chk(a);
    end
    $display("program test done");
    op(OP_BLK_ERASE, a0, 8'h00); cmp1(erase_busy, 1'b0);
    erase_exp(a0, 0);
    rd_chk(a0);
    op(OP_ADD_BLK, a, 8'h00);
    op(OP_READ, a, 8'h00); cmp1(op_rdata[7], 1'b0);
    // no polling behind this op: read here until the toggle bit settles
    do begin
      pv = op_rdata;
      op(OP_READ, a, 8'h00);
    end while (op_rdata[TOGGLE_BIT] !== pv[TOGGLE_BIT]);
    erase_exp(a, 0);
    rd_chk(a);
    $display("block erase test done");
    op(OP_PAUSE, 20'h00000, 8'h00); cmp1(erase_paused, 1'b1);
    op(OP_PROGRAM, 20'h80010, 8'h3C);
    exp_mem[20'h80010] = 8'h3C;
    rd_chk(20'h80010);
    cmp1(erase_paused, 1'b1);
    op(OP_CONTINUE, 20'h00000, 8'h00); cmp1(erase_paused, 1'b0);
    $display("pause test done");
    op(OP_CHIP_ERASE, 20'h00000, 8'h00); cmp1(erase_busy, 1'b0);
    erase_exp(20'h00000, 1);
    rd_chk(20'h80010);
    op(OP_PROGRAM, 20'h00100, 8'h81);
    exp_mem[20'h00100] = 8'h81;
    op(OP_RESET, 20'h00000, 8'h00);
    rd_chk(20'h00100);
    // reset of a paused flash: three writes of four cycles, then the recovery wait
    op(OP_PAUSE, 20'h00000, 8'h00);
    n0 = cycles;
    op(OP_RESET, 20'h00000, 8'h00); cmp1(erase_paused, 1'b0);
    cmp1((cycles - n0) > (RECOVER_CYC + 8'h0C), 1'b1);
    rd_chk(20'h00100);
    $display("erase and reset test done");
    test_done;
  end
endmodule
